// [hdl/host_port_pkg.sv]
`default_nettype none
// ==========================================================================
// Shared constants and carriers for the SRAM-style host port
package host_port_pkg;
  // Pin and path widths
  localparam int ADDR_W = 7;            // Word address pins, A7..A1
  localparam int HALF_W = 16;           // Host data bus
  localparam int WORD_W = 32;           // Internal data path
  localparam int WADDR_W = 6;           // Internal 32-bit word index, A7..A2
  localparam int IRQ_SRC_W = 8;         // Interrupt sources offered to the pin
  // Field positions inside the host address
  localparam int HALF_SEL_BIT = 0;      // A1 picks the low or high half
  localparam int WADDR_LSB = 1;         // A2 is the lowest word index bit
  // Pin bundle layout, first synchroniser input
  localparam int PIN_W = ADDR_W + HALF_W + 4;
  // Timing: internal read data follow the request by this many cycles
  localparam int READ_LATENCY = 1;
  // Reset values, and the word index used in FIFO mode
  localparam logic [HALF_W-1:0] HALF_RST = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [WADDR_W-1:0] WADDR_RST = 6'h00;
  localparam logic [WADDR_W-1:0] FIFO_WADDR = 6'h00;

  // Synchronised host pins
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic fifo_sel;
    logic [ADDR_W-1:0] addr;
    logic [HALF_W-1:0] data;
  } host_pins_t;

  // One-cycle request towards the registers and FIFOs
  typedef struct packed {
    logic wr;
    logic rd;
    logic fifo;
    logic [WADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } int_req_t;
endpackage : host_port_pkg
`default_nettype wire

// [hdl/pin_sync.sv]
`default_nettype none
// ==========================================================================
// Two-stage synchroniser bank for asynchronous pins
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second; reset state is all ones so strobes look idle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else if (ce_in) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : pin_sync
`default_nettype wire

// [hdl/host_port_pins.sv]
// Function
// R1 - Address A7..A1 selects registers or FIFOs by word index.
// R2 - Read strobe low marks a read access.
// R3 - Write strobe low marks a write access.
// R4 - Strobes count only while chip select is low.
// R5 - In low power, a qualified write raises the wake pulse.
// R6 - Interrupt pin: programmable polarity, source enables, push-pull or open-drain.
// R7 - FIFO select high routes accesses to FIFOs, ignoring A7..A3. Code: A2 is ignored too, the word index is fixed at 0.
// R8 - Two 16-bit host accesses make one 32-bit internal word.
// R9 - Host reads once after reset or wake before writes take effect.
// R10 - Host aims its wake-up write at the endian test register.
// R11 - Port is asynchronous; accesses framed only by chip select and strobes.
// R12 - Data bus driven only while chip select and read strobe are low. Code: drive follows the synchronised strobes, two cycles late.
`default_nettype none
// ==========================================================================
// Host port top
module host_port_pins (
  // Clock, reset, enable
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  // Host bus pins
  input wire logic [host_port_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic CHIP_SELECT_N_IN,
  input wire logic READ_STROBE_N_IN,
  input wire logic WRITE_STROBE_N_IN,
  input wire logic FIFO_SELECT_IN,
  input wire logic [host_port_pkg::HALF_W-1:0] DATA_IN,
  output logic [host_port_pkg::HALF_W-1:0] DATA_OUT,
  output logic DATA_OE_OUT,
  // Internal register and FIFO side
  output var host_port_pkg::int_req_t INT_REQ_OUT,
  input wire logic [host_port_pkg::WORD_W-1:0] INT_RD_DATA_IN,
  // Power management
  input wire logic LOW_POWER_IN,
  output logic WAKE_OUT,
  // Interrupt pin and its configuration
  input wire logic [host_port_pkg::IRQ_SRC_W-1:0] IRQ_EVENTS_IN,
  input wire logic [host_port_pkg::IRQ_SRC_W-1:0] IRQ_ENABLE_IN,
  input wire logic IRQ_ACTIVE_HIGH_IN,
  input wire logic IRQ_OPEN_DRAIN_IN,
  output logic IRQ_OUT,
  output logic IRQ_OE_OUT
);
  // ========================================================================
  // Pin synchronisation
  typedef enum {ST_IDLE, ST_FETCH} rd_state_t;

  host_port_pkg::host_pins_t pins_raw;
  host_port_pkg::host_pins_t pins_s;
  logic rd_act;
  logic wr_act;
  logic rd_act_ff;
  logic wr_act_ff;
  logic rd_start;
  logic wr_start;
  logic half_hi;
  logic [host_port_pkg::WADDR_W-1:0] waddr;
  rd_state_t state_ff;
  logic [host_port_pkg::HALF_W-1:0] lo_wr_ff;
  logic [host_port_pkg::HALF_W-1:0] hi_rd_ff;
  logic [host_port_pkg::HALF_W-1:0] data_ff;
  logic armed_ff;
  logic wake_ff;
  host_port_pkg::int_req_t req_ff;
  logic irq_active;
  logic irq_ff;
  logic irq_oe_ff;

  assign pins_raw = '{cs_n: CHIP_SELECT_N_IN, rd_n: READ_STROBE_N_IN,
                      wr_n: WRITE_STROBE_N_IN, fifo_sel: FIFO_SELECT_IN,
                      addr: ADDR_IN, data: DATA_IN};

  pin_sync #(
    .WIDTH(host_port_pkg::PIN_W)
  ) u_sync (
    .clk_in(CORE_CLK_IN),
    .rstn_in(RSTN_IN),
    .ce_in(CE_IN),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // ========================================================================
  // Access framing: no bus clock, so strobe levels are sampled here
  assign rd_act = !pins_s.cs_n && !pins_s.rd_n;  // [R2] [R4] [R11]
  assign wr_act = !pins_s.cs_n && !pins_s.wr_n;  // [R3] [R4] [R11]
  assign rd_start = rd_act && !rd_act_ff;
  assign wr_start = wr_act && !wr_act_ff;
  assign half_hi = pins_s.addr[host_port_pkg::HALF_SEL_BIT];

  // FIFO mode keeps only A1, so the word index collapses to one slot
  assign waddr = pins_s.fifo_sel ? host_port_pkg::FIFO_WADDR :
                 pins_s.addr[host_port_pkg::ADDR_W-1:host_port_pkg::WADDR_LSB];  // [R1] [R7]

  // Previous strobe levels for start detection
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      rd_act_ff <= 1'b0;
      wr_act_ff <= 1'b0;
    end else if (CE_IN) begin
      rd_act_ff <= rd_act;
      wr_act_ff <= wr_act;
    end
  end

  // ========================================================================
  // Write arming: writes are dropped until a read follows reset or wake
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      armed_ff <= 1'b0;
    end else if (CE_IN) begin
      if (rd_start) begin
        armed_ff <= 1'b1;  // [R9]
      end else if (wake_ff) begin
        armed_ff <= 1'b0;  // [R9]
      end
    end
  end

  // Wake pulse; the waking write is not forwarded, it only wakes
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      wake_ff <= 1'b0;
    end else if (CE_IN) begin
      wake_ff <= wr_start && LOW_POWER_IN;  // [R5] [R10]
    end
  end

  assign WAKE_OUT = wake_ff;

  // ========================================================================
  // Internal request: low half writes are held, high half write sends the word
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      lo_wr_ff <= host_port_pkg::HALF_RST;
      req_ff <= '{wr: 1'b0, rd: 1'b0, fifo: 1'b0, addr: host_port_pkg::WADDR_RST,
                  data: host_port_pkg::WORD_RST};
    end else if (CE_IN) begin
      req_ff.wr <= 1'b0;
      req_ff.rd <= 1'b0;
      if (wr_start && !LOW_POWER_IN && armed_ff) begin
        if (half_hi) begin
          req_ff.wr <= 1'b1;  // [R8]
          req_ff.fifo <= pins_s.fifo_sel;  // [R7]
          req_ff.addr <= waddr;  // [R1]
          req_ff.data <= {pins_s.data, lo_wr_ff};  // [R8]
        end else begin
          lo_wr_ff <= pins_s.data;  // [R8]
        end
      end else if (rd_start && !half_hi) begin
        // Low half read fetches the whole word; a stalled FIFO pop would lose data
        req_ff.rd <= 1'b1;  // [R8]
        req_ff.fifo <= pins_s.fifo_sel;  // [R7]
        req_ff.addr <= waddr;  // [R1]
      end
    end
  end

  assign INT_REQ_OUT = req_ff;

  // ========================================================================
  // Read path: low half returns fetched word bits 15..0, high half the saved rest
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      state_ff <= ST_IDLE;
      data_ff <= host_port_pkg::HALF_RST;
      hi_rd_ff <= host_port_pkg::HALF_RST;
    end else if (CE_IN) begin
      case (state_ff)
        ST_IDLE: begin
          if (req_ff.rd) begin
            state_ff <= ST_FETCH;
          end else if (rd_start && half_hi) begin
            data_ff <= hi_rd_ff;  // [R8]
          end
        end
        ST_FETCH: begin
          data_ff <= INT_RD_DATA_IN[host_port_pkg::HALF_W-1:0];  // [R8]
          hi_rd_ff <= INT_RD_DATA_IN[host_port_pkg::WORD_W-1:host_port_pkg::HALF_W];
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign DATA_OUT = data_ff;
  // Bus drive follows the synchronised strobes, so it trails the pins by two cycles
  assign DATA_OE_OUT = rd_act;  // [R12]

  // ========================================================================
  // Interrupt pin: open-drain only drives while asserting, to allow sharing
  assign irq_active = |(IRQ_EVENTS_IN & IRQ_ENABLE_IN);  // [R6]

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      irq_ff <= 1'b0;
      irq_oe_ff <= 1'b0;
    end else if (CE_IN) begin
      if (IRQ_OPEN_DRAIN_IN) begin
        irq_ff <= IRQ_ACTIVE_HIGH_IN;  // [R6]
        irq_oe_ff <= irq_active;  // [R6]
      end else begin
        irq_ff <= (irq_active == IRQ_ACTIVE_HIGH_IN);  // [R6]
        irq_oe_ff <= 1'b1;  // [R6]
      end
    end
  end

  assign IRQ_OUT = irq_ff;
  assign IRQ_OE_OUT = irq_oe_ff;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RSTN_IN || !CE_IN);

  sequence s_fetch;
    req_ff.rd ##1 state_ff == ST_FETCH;
  endsequence

  // Drive must trace back to select and read strobe at the pins, two flops earlier
  a_oe_needs_cs: assert property (DATA_OE_OUT |->  // [R12]
      $past(!CHIP_SELECT_N_IN && !READ_STROBE_N_IN, 2))
    else $error("Data bus driven without chip select");
  a_wake_on_write: assert property ((wr_start && LOW_POWER_IN) |=> WAKE_OUT)  // [R5]
    else $error("Qualified write in low power did not wake");
  a_wake_only_write: assert property (WAKE_OUT |-> $past(wr_act) && $past(LOW_POWER_IN))  // [R5]
    else $error("Wake pulse without a write in low power");
  a_fetch_on_lo: assert property ((rd_start && !half_hi && !wr_start) |=> INT_REQ_OUT.rd)  // [R8]
    else $error("Low half read did not fetch a word");
  a_read_data: assert property (s_fetch |=> DATA_OUT == $past(INT_RD_DATA_IN[15:0]))  // [R8]
    else $error("Fetched low half not presented");
  a_write_pair: assert property (INT_REQ_OUT.wr |-> $past(wr_start && half_hi && armed_ff))  // [R8]
    else $error("Word write without high half write");
  a_write_armed: assert property (!armed_ff && wr_start |=> !INT_REQ_OUT.wr)  // [R9]
    else $error("Write forwarded before first read");
  a_fifo_addr: assert property ((INT_REQ_OUT.wr || INT_REQ_OUT.rd) && INT_REQ_OUT.fifo  // [R7]
                                |-> INT_REQ_OUT.addr == 6'h00)
    else $error("FIFO access kept upper address bits");
  a_csr_decode: assert property ((rd_start && !half_hi && !pins_s.fifo_sel && !wr_start)  // [R1]
                                 |=> INT_REQ_OUT.addr == $past(pins_s.addr[6:1]))
    else $error("Register word index decoded wrongly");
  a_irq_push_pull: assert property (!IRQ_OPEN_DRAIN_IN |=> IRQ_OE_OUT &&  // [R6]
      IRQ_OUT == ($past(irq_active) == $past(IRQ_ACTIVE_HIGH_IN)))
    else $error("Push-pull interrupt level wrong");
  a_irq_open_drain: assert property (IRQ_OPEN_DRAIN_IN |=> IRQ_OE_OUT == $past(irq_active))  // [R6]
    else $error("Open-drain interrupt drive wrong");
endmodule : host_port_pins
`default_nettype wire

// [test/host_bus_model.sv]
`default_nettype none
// ==========================================================================
// Embedded host processor on the SRAM-style pins
module host_bus_model (
  // Clock used only to pace the host's own timing
  input wire logic clk_in,
  // Device side of the data bus
  input wire logic [15:0] data_in,
  input wire logic data_oe_in,
  // Host pins
  output logic [6:0] addr_out,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic fifo_sel_out,
  output logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus: strobes and select high
  initial begin
    addr_out = 7'h00;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    fifo_sel_out = 1'b0;
    data_out = 16'h0000;
  end

  // One access framed only by select and strobe, no bus clock
  task automatic access(input logic wr, input logic cs, input logic fifo, input logic [6:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic oe);
    @(negedge clk_in);
    addr_out = a;
    fifo_sel_out = fifo;
    data_out = d;
    cs_n_out = ~cs;
    rd_n_out = wr;
    wr_n_out = ~wr;
    // Long low phase: pins pass two flops and low half data land at start+5
    repeat (8) @(negedge clk_in);
    q = data_in;
    oe = data_oe_in;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    data_out = ~d; // Released bus must not keep the old value
    repeat (5) @(negedge clk_in);
  endtask : access
endmodule : host_bus_model
`default_nettype wire

// [test/sram_style_host_port_pins_test.sv]
`default_nettype none
// ==========================================================================
// Self-checking bench for the host port
module sram_style_host_port_pins_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic fifo;
    logic [5:0] idx;
    logic [31:0] data;
    logic [5:0] exp_idx;
  } row_t;
  localparam logic [5:0] TEST_REG_IDX = 6'h19; // Endian test word, arbitrary index
  logic clk = 1'b0, rstn = 1'b0, low_pwr = 1'b0, irq_pol = 1'b1, irq_od = 1'b0, ce = 1'b1;
  logic [7:0] irq_ev = 8'h00, irq_en = 8'h00;
  logic [6:0] addr;
  logic cs_n, rd_n, wr_n, fsel, oe, wake, irq, irq_oe, qoe;
  logic [15:0] din, dout, q;
  logic [31:0] rdata;
  host_port_pkg::int_req_t req, last_wr;
  int fails = 0, check_count = 0, wr_cnt = 0, wake_cnt = 0, n;
  row_t rows [4] = '{'{1'b0, 6'h00, 32'h1234_5678, 6'h00}, '{1'b0, 6'h3f, 32'hffff_0001, 6'h3f},
    '{1'b0, 6'h15, 32'h8000_7ffe, 6'h15}, '{1'b1, 6'h3e, 32'hdead_beef, 6'h00}};

  initial forever #5 clk = ~clk;
  // Internal side answers from the held word index and route, so each request reads differently
  assign rdata = {10'h2a5, req.addr, 9'h061, req.fifo, req.addr};

  host_port_pins dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .ADDR_IN(addr),
    .CHIP_SELECT_N_IN(cs_n), .READ_STROBE_N_IN(rd_n), .WRITE_STROBE_N_IN(wr_n),
    .FIFO_SELECT_IN(fsel), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(oe),
    .INT_REQ_OUT(req), .INT_RD_DATA_IN(rdata), .LOW_POWER_IN(low_pwr), .WAKE_OUT(wake),
    .IRQ_EVENTS_IN(irq_ev), .IRQ_ENABLE_IN(irq_en), .IRQ_ACTIVE_HIGH_IN(irq_pol),
    .IRQ_OPEN_DRAIN_IN(irq_od), .IRQ_OUT(irq), .IRQ_OE_OUT(irq_oe));
  host_bus_model host (.clk_in(clk), .data_in(dout), .data_oe_in(oe), .addr_out(addr),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .fifo_sel_out(fsel), .data_out(din));

  // Count pulses at the falling edge, where the registered outputs have settled
  always @(negedge clk) begin
    if (req.wr === 1'b1) begin
      last_wr <= req;
      wr_cnt++;
    end
    if (wake === 1'b1) wake_cnt++;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // Cut a hang short; the full run takes about 4 us
  initial begin
    #100us;
    fails++;
    end_of_test();
  end

  // Two-cycle synchronous reset, then the outputs must be at rest
  task automatic do_reset;
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk({req, oe, wake, irq, irq_oe}, '0, "reset outputs");
    rstn = 1'b1;
  endtask : do_reset

  initial begin
    do_reset();
    // ========================================================================
    // Table of write pairs and read-backs
    host.access(1'b0, 1'b1, 1'b0, 7'h54, 16'h0000, q, qoe); // First read arms writes
    foreach (rows[i]) begin
      // Read first, so the word index must come from the read, not from a leftover write
      host.access(1'b0, 1'b1, rows[i].fifo, {rows[i].idx, 1'b0}, 16'h0000, q, qoe);
      chk(q, {9'h061, rows[i].fifo, rows[i].exp_idx}, "read low");
      chk(qoe, 1'b1, "bus not driven in read");
      host.access(1'b0, 1'b1, rows[i].fifo, {rows[i].idx, 1'b1}, 16'h0000, q, qoe);
      chk(q, {10'h2a5, rows[i].exp_idx}, "read high");
      chk(oe, 1'b0, "bus held after release");
      n = wr_cnt;
      host.access(1'b1, 1'b1, rows[i].fifo, {rows[i].idx, 1'b0}, rows[i].data[15:0], q, qoe);
      chk(wr_cnt, n, "low half alone");
      chk(qoe, 1'b0, "bus driven in write");
      host.access(1'b1, 1'b1, rows[i].fifo, {rows[i].idx, 1'b1}, rows[i].data[31:16], q, qoe);
      chk(wr_cnt, n + 1, "write pair count");
      chk(last_wr.data, rows[i].data, "write word");
      chk(last_wr.addr, rows[i].exp_idx, "write index");
      chk(last_wr.fifo, rows[i].fifo, "fifo route");
    end
    $display("table test done");
    // ========================================================================
    // Reset mid-run: writes dropped until a read
    do_reset();
    n = wr_cnt;
    host.access(1'b1, 1'b1, 1'b0, 7'h04, 16'h1111, q, qoe);
    host.access(1'b1, 1'b1, 1'b0, 7'h05, 16'h2222, q, qoe);
    chk(wr_cnt, n, "write before first read");
    $display("reset test done");
    // ========================================================================
    // Strobes without select; wake only on a selected write
    host.access(1'b0, 1'b0, 1'b0, 7'h02, 16'h0000, q, qoe);
    chk(qoe, 1'b0, "driven without select");
    host.access(1'b0, 1'b1, 1'b0, 7'h54, 16'h0000, q, qoe); // Arm so the unselected pair below is dropped only for lack of select
    host.access(1'b1, 1'b0, 1'b0, 7'h02, 16'h6666, q, qoe);
    host.access(1'b1, 1'b0, 1'b0, 7'h03, 16'h3333, q, qoe);
    chk(wr_cnt, n, "write without select");
    low_pwr = 1'b1;
    host.access(1'b1, 1'b0, 1'b0, {TEST_REG_IDX, 1'b0}, 16'h0000, q, qoe);
    chk(wake_cnt, 0, "wake without select");
    host.access(1'b1, 1'b1, 1'b0, {TEST_REG_IDX, 1'b0}, 16'h0000, q, qoe);
    chk(wake_cnt, 1, "wake pulse");
    chk(wr_cnt, n, "wake write forwarded");
    low_pwr = 1'b0;
    host.access(1'b1, 1'b1, 1'b0, 7'h06, 16'h4444, q, qoe);
    host.access(1'b1, 1'b1, 1'b0, 7'h07, 16'h5555, q, qoe);
    chk(wr_cnt, n, "write after wake without read");
    $display("select and wake test done");
    // ========================================================================
    // Interrupt pin in all polarity and driver modes, source masked and unmasked
    for (int p = 0; p < 4; p++) begin
      @(negedge clk);
      irq_pol = p[0];
      irq_od = p[1];
      irq_en = 8'h08;
      irq_ev = 8'h08;
      repeat (3) @(negedge clk);
      chk({irq, irq_oe}, {irq_pol, 1'b1}, "irq asserted");
      irq_en = 8'hf7;
      repeat (3) @(negedge clk);
      chk(irq_oe, !irq_od, "irq masked drive");
      if (!irq_od) chk(irq, !irq_pol, "irq masked level");
    end
    // Clock enable low freezes the pin state even though the source unmasks
    @(negedge clk);
    ce = 1'b0;
    irq_en = 8'h08;
    repeat (3) @(negedge clk);
    chk(irq_oe, 1'b0, "irq frozen by enable");
    ce = 1'b1;
    repeat (3) @(negedge clk);
    chk({irq, irq_oe}, 2'b11, "irq after enable");
    $display("interrupt test done");
    end_of_test();
  end
endmodule : sram_style_host_port_pins_test
`default_nettype wire
